// ### hdl/audio_port_tx_defs.svh
`ifndef AUDIO_PORT_TX_DEFS_SVH
`define AUDIO_PORT_TX_DEFS_SVH
// Overview of operation
// - per-channel select bit: clear routes channel to primary pin, set to secondary
// - channel one enable clear makes its slot an unused cycle; set sends channel one data
// - channel two enable set sends channel two data; clear makes its slot an unused cycle
// - after reset all pin-select bits are zero, everything on primary pin
// - after reset channel one is enabled in slot zero, byte 0x20
// - after reset channel two is enabled in slot one, byte 0x21
// - unused cycles drive zero, or high impedance when fill option set
// - slot zero MSB delayed by programmed 0-31 bit clocks on both pins, by one clock more in i2s

// register indices; byte address is four times the index
`define IDX_TX_FILL 8'h1B
`define IDX_TX_OFFSET 8'h1C
`define IDX_PIN_SEL 8'h1D
`define IDX_CH1_CFG 8'h1E
`define IDX_CH2_CFG 8'h1F
`define IDX_FRAME_FMT 8'h30

`define FILL_BIT 6
`define CH_EN_BIT 5

`define RST_FILL 1'h0
`define RST_OFFSET 5'h00
`define RST_PIN_SEL 8'h00
`define RST_CH1_CFG 6'h20
`define RST_CH2_CFG 6'h21
`define RST_FRAME_FMT 4'h0

`define WL_LAST_16 5'h0F
`define WL_LAST_20 5'h13
`define WL_LAST_24 5'h17
`define WL_LAST_32 5'h1F
`define TDM_LAST_SLOT 5'h1F
`define HALF_LAST_SLOT 5'h0F
`define I2S_STD_OFFSET 6'h01
`endif

// ### hdl/audio_port_tx_pkg.sv
package audio_port_tx_pkg;
	typedef enum logic [1:0] {
		FMT_TDM = 2'h0,
		FMT_I2S = 2'h1,
		FMT_LJ = 2'h2
	} fmt_e;
	typedef enum logic [1:0] {
		POS_IDLE = 2'h0,
		POS_SKIP = 2'h1,
		POS_SHIFT = 2'h3,
		POS_DONE = 2'h2
	} pos_e;
endpackage

// ### hdl/link_sync.sv
`timescale 1ns/1ns
`default_nettype none
module link_sync #(
	parameter int width = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous levels in, synchronised out
	input wire logic [width-1:0] d,
	output logic [width-1:0] q
);
	logic [width-1:0] meta_reg;

	if (width < 1) begin : g_chk
		$error("link_sync width must be at least one");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // link_sync
`default_nettype wire

// ### hdl/audio_port_tx_slot_mapper.sv
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_tx_defs.svh"
module audio_port_tx_slot_mapper #(
	parameter int num_ch = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial link inputs
	input wire logic bclk,
	input wire logic fsync,
	// channel samples, msb-justified
	input wire logic [31:0] ch1_sample,
	input wire logic [31:0] ch2_sample,
	// data pins
	output logic primary_data_out,
	output logic primary_data_oe,
	output logic secondary_data_out,
	output logic secondary_data_oe
);
	import audio_port_tx_pkg::*;

	logic fill_reg, fill_next;
	logic [4:0] offset_reg, offset_next;
	logic [7:0] pin_sel_reg, pin_sel_next;
	logic [5:0] ch1_cfg_reg, ch1_cfg_next;
	logic [5:0] ch2_cfg_reg, ch2_cfg_next;
	logic [3:0] fmt_reg, fmt_next;
	logic wr_pend_reg;
	logic [7:0] wr_idx_reg;
	logic ap_take;
	logic [7:0] rd_byte;
	logic [1:0] link_s;
	logic bclk_d_reg, fs_prev_reg;
	logic bclk_rise, bclk_fall, fs_up, fs_dn;
	logic is_tdm, is_i2s, start_any, start_right;
	logic [5:0] skip_total;
	logic [4:0] wl_last, last_slot;
	pos_e pos_reg;
	logic [5:0] skip_cnt_reg;
	logic [4:0] bit_idx_reg, slot_idx_reg;
	logic half_reg;
	logic [5:0] ch_cfg [num_ch];
	logic [31:0] ch_sample [num_ch];
	logic [31:0] sample_hold_reg [num_ch];
	logic [num_ch-1:0] slot_ok, ch_hit, ch_bit;
	logic pri_hit, pri_bit, sec_hit, sec_bit;

	if (num_ch < 1 || num_ch > 2) begin : g_chk
		$error("num_ch must be 1 or 2");
	end

	// bus: zero wait state, always okay
	assign ap_take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'h0;
			wr_idx_reg <= 8'h00;
			hreadyout <= 1'h0;
			hresp <= 1'h0;
		end else begin
			wr_pend_reg <= ap_take && hwrite;
			wr_idx_reg <= haddr[9:2];
			hreadyout <= 1'h1;
			hresp <= 1'h0;
		end
	end

	// pending write merged into next values so a read right behind it sees it
	always_comb begin
		fill_next = fill_reg;
		offset_next = offset_reg;
		pin_sel_next = pin_sel_reg;
		ch1_cfg_next = ch1_cfg_reg;
		ch2_cfg_next = ch2_cfg_reg;
		fmt_next = fmt_reg;
		if (wr_pend_reg) begin
			case (wr_idx_reg)
				`IDX_TX_FILL: fill_next = hwdata[`FILL_BIT];
				`IDX_TX_OFFSET: offset_next = hwdata[4:0];
				`IDX_PIN_SEL: pin_sel_next = hwdata[7:0];
				`IDX_CH1_CFG: ch1_cfg_next = hwdata[5:0];
				`IDX_CH2_CFG: ch2_cfg_next = hwdata[5:0];
				`IDX_FRAME_FMT: fmt_next = hwdata[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fill_reg <= `RST_FILL;
			offset_reg <= `RST_OFFSET;
			pin_sel_reg <= `RST_PIN_SEL;
			ch1_cfg_reg <= `RST_CH1_CFG;
			ch2_cfg_reg <= `RST_CH2_CFG;
			fmt_reg <= `RST_FRAME_FMT;
		end else begin
			fill_reg <= fill_next;
			offset_reg <= offset_next;
			pin_sel_reg <= pin_sel_next;
			ch1_cfg_reg <= ch1_cfg_next;
			ch2_cfg_reg <= ch2_cfg_next;
			fmt_reg <= fmt_next;
		end
	end

	always_comb begin
		case (haddr[9:2])
			`IDX_TX_FILL: rd_byte = {1'h0, fill_next, 6'h00};
			`IDX_TX_OFFSET: rd_byte = {3'h0, offset_next};
			`IDX_PIN_SEL: rd_byte = pin_sel_next;
			`IDX_CH1_CFG: rd_byte = {2'h0, ch1_cfg_next};
			`IDX_CH2_CFG: rd_byte = {2'h0, ch2_cfg_next};
			`IDX_FRAME_FMT: rd_byte = {4'h0, fmt_next};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (ap_take && !hwrite)
			hrdata <= {24'h0, rd_byte};
	end

	// link edges, found on the synchronised bit clock
	link_sync #(.width(2)) link_sync_inst (
		.clk(hclk),
		.rst_n(hresetn),
		.d({fsync, bclk}),
		.q(link_s)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bclk_d_reg <= 1'h0;
			fs_prev_reg <= 1'h0;
		end else begin
			bclk_d_reg <= link_s[0];
			if (bclk_rise)
				fs_prev_reg <= link_s[1];
		end
	end

	assign bclk_rise = link_s[0] && !bclk_d_reg;
	assign bclk_fall = !link_s[0] && bclk_d_reg;
	assign fs_up = link_s[1] && !fs_prev_reg;
	assign fs_dn = !link_s[1] && fs_prev_reg;
	assign is_tdm = fmt_reg[1:0] == FMT_TDM;
	assign is_i2s = fmt_reg[1:0] == FMT_I2S;
	// i2s: left half opens on the falling frame sync, right on the rising one
	assign start_any = is_tdm ? fs_up : (fs_up || fs_dn);
	assign start_right = !is_tdm && (is_i2s ? fs_up : fs_dn);
	assign skip_total = {1'h0, offset_reg} + (is_i2s ? `I2S_STD_OFFSET : 6'h00);
	assign last_slot = is_tdm ? `TDM_LAST_SLOT : `HALF_LAST_SLOT;

	always_comb begin
		case (fmt_reg[3:2])
			2'h0: wl_last = `WL_LAST_16;
			2'h1: wl_last = `WL_LAST_20;
			2'h2: wl_last = `WL_LAST_24;
			default: wl_last = `WL_LAST_32;
		endcase
	end

	// frame position: skip the msb delay, then walk bits and slots
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_reg <= POS_IDLE;
			skip_cnt_reg <= 6'h00;
			bit_idx_reg <= 5'h00;
			slot_idx_reg <= 5'h00;
			half_reg <= 1'h0;
		end else if (bclk_rise) begin
			if (start_any) begin
				half_reg <= start_right;
				bit_idx_reg <= 5'h00;
				slot_idx_reg <= 5'h00;
				skip_cnt_reg <= skip_total;
				pos_reg <= (skip_total == 6'h00) ? POS_SHIFT : POS_SKIP;
			end else begin
				case (pos_reg)
					POS_SKIP: begin
						skip_cnt_reg <= skip_cnt_reg - 6'h01;
						if (skip_cnt_reg == 6'h01)
							pos_reg <= POS_SHIFT;
					end
					POS_SHIFT: begin
						bit_idx_reg <= bit_idx_reg + 5'h01;
						if (bit_idx_reg == wl_last) begin
							bit_idx_reg <= 5'h00;
							slot_idx_reg <= slot_idx_reg + 5'h01;
							if (slot_idx_reg == last_slot)
								pos_reg <= POS_DONE;
						end
					end
					default: pos_reg <= pos_reg;
				endcase
			end
		end
	end

	assign ch_cfg[0] = ch1_cfg_reg;
	assign ch_sample[0] = ch1_sample;
	if (num_ch > 1) begin : g_ch2
		assign ch_cfg[1] = ch2_cfg_reg;
		assign ch_sample[1] = ch2_sample;
	end

	for (genvar g = 0; g < num_ch; g++) begin : g_ch
		assign slot_ok[g] = is_tdm ? (slot_idx_reg == ch_cfg[g][4:0]) :
			(half_reg == ch_cfg[g][4] && slot_idx_reg[3:0] == ch_cfg[g][3:0]);
		assign ch_hit[g] = ch_cfg[g][`CH_EN_BIT] && pos_reg == POS_SHIFT && slot_ok[g];
		assign ch_bit[g] = sample_hold_reg[g][~bit_idx_reg];
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				sample_hold_reg[g] <= 32'h0;
			else if (bclk_rise && start_any)
				sample_hold_reg[g] <= ch_sample[g];
		end
	end

	// lowest channel assigned last so it wins a shared slot
	always_comb begin
		pri_hit = 1'h0;
		pri_bit = 1'h0;
		sec_hit = 1'h0;
		sec_bit = 1'h0;
		for (int c = num_ch - 1; c >= 0; c--) begin
			if (ch_hit[c]) begin
				if (pin_sel_reg[c]) begin
					sec_hit = 1'h1;
					sec_bit = ch_bit[c];
				end else begin
					pri_hit = 1'h1;
					pri_bit = ch_bit[c];
				end
			end
		end
	end

	// data change on the falling bit clock, receiver samples on the rising one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primary_data_out <= 1'h0;
			primary_data_oe <= 1'h0;
			secondary_data_out <= 1'h0;
			secondary_data_oe <= 1'h0;
		end else if (bclk_fall) begin
			primary_data_out <= pri_hit && pri_bit;
			primary_data_oe <= pri_hit || !fill_reg;
			secondary_data_out <= sec_hit && sec_bit;
			secondary_data_oe <= sec_hit || !fill_reg;
		end
	end

	property p_sec_route;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && ch_hit[0] && pin_sel_reg[0] |=> secondary_data_oe && secondary_data_out == $past(ch_bit[0]);
	endproperty
	a_sec_route: assert property (p_sec_route) else $error("channel one not on secondary pin");

	property p_ch1_off;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && fill_reg && !ch1_cfg_reg[`CH_EN_BIT] && !ch_hit[num_ch-1] |=> !primary_data_oe && !secondary_data_oe;
	endproperty
	a_ch1_off: assert property (p_ch1_off) else $error("disabled channel one drives a pin");

	property p_ch2_on;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && ch2_cfg_reg[`CH_EN_BIT] && pos_reg == POS_SHIFT && slot_ok[num_ch-1] && !ch_hit[0]
			&& !pin_sel_reg[num_ch-1] |=> primary_data_oe && primary_data_out == $past(ch_bit[num_ch-1]);
	endproperty
	a_ch2_on: assert property (p_ch2_on) else $error("enabled channel two not transmitted");

	property p_tdm_slot;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && is_tdm && pos_reg == POS_SHIFT && ch1_cfg_reg[`CH_EN_BIT] && slot_idx_reg == ch1_cfg_reg[4:0]
			&& !pin_sel_reg[0] |=> primary_data_oe && primary_data_out == $past(sample_hold_reg[0][~bit_idx_reg]);
	endproperty
	a_tdm_slot: assert property (p_tdm_slot) else $error("tdm slot not selected");

	property p_half_slot;
		@(posedge hclk) disable iff (!hresetn)
		!is_tdm && pos_reg == POS_SHIFT && ch_hit[0] |-> half_reg == ch1_cfg_reg[4] && slot_idx_reg[4] == 1'h0;
	endproperty
	a_half_slot: assert property (p_half_slot) else $error("half slot mismatch");

	property p_pin_reset;
		@(posedge hclk) disable iff (!hresetn)
		!$past(hresetn) |-> pin_sel_reg == 8'h00;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin select not cleared by reset");

	property p_ch1_reset;
		@(posedge hclk) disable iff (!hresetn)
		!$past(hresetn) |-> ch1_cfg_reg == 6'h20;
	endproperty
	a_ch1_reset: assert property (p_ch1_reset) else $error("channel one reset value wrong");

	property p_ch2_reset;
		@(posedge hclk) disable iff (!hresetn)
		!$past(hresetn) |-> ch2_cfg_reg == 6'h21;
	endproperty
	a_ch2_reset: assert property (p_ch2_reset) else $error("channel two reset value wrong");

	property p_fill;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && !pri_hit |=> primary_data_oe == !$past(fill_reg) && !primary_data_out;
	endproperty
	a_fill: assert property (p_fill) else $error("unused cycle fill wrong");

	property p_skip;
		@(posedge hclk) disable iff (!hresetn)
		bclk_rise && start_any && skip_total != 6'h00 |=> pos_reg == POS_SKIP && skip_cnt_reg == $past(skip_total);
	endproperty
	a_skip: assert property (p_skip) else $error("msb delay not loaded");

	property p_prio;
		@(posedge hclk) disable iff (!hresetn)
		bclk_fall && ch_hit[0] && ch_hit[num_ch-1] && !pin_sel_reg[0] && !pin_sel_reg[num_ch-1]
			|=> primary_data_out == $past(ch_bit[0]);
	endproperty
	a_prio: assert property (p_prio) else $error("lower channel lost a shared slot");
endmodule // audio_port_tx_slot_mapper
`default_nettype wire

// ### test/audio_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module audio_host_model (
	// link clock and frame sync toward the block
	output logic bclk,
	output logic fsync,
	// data pins from the block
	input wire logic primary_data_out,
	input wire logic primary_data_oe,
	input wire logic secondary_data_out,
	input wire logic secondary_data_oe
);
	logic pri_bits [0:599];
	logic sec_bits [0:599];

	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
	end

	// two idle cycles, frame start at rise 2, bit j taken at fall j+3 before the block moves
	task automatic run_frame(input int fmt, input int nbits, input int hl);
		for (int i = 0; i <= nbits + 2; i++) begin
			fsync = (fmt != 0) ? (i >= 2 && i < 2 + hl) : (i == 2);
			#80 bclk = 1'b1;
			#80 bclk = 1'b0;
			if (i >= 3) begin
				pri_bits[i - 3] = primary_data_oe ? primary_data_out : 1'bz;
				sec_bits[i - 3] = secondary_data_oe ? secondary_data_out : 1'bz;
			end
		end
	endtask
endmodule // audio_host_model
`default_nettype wire

// ### test/audio_port_tx_slot_mapper_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_tx_defs.svh"
module audio_port_tx_slot_mapper_tb;
	import audio_port_tx_pkg::*;
	localparam logic [15:0] s1 = 16'hA5C3;
	localparam logic [15:0] s2 = 16'h3C96;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bclk, fsync, p_d, p_oe, s_d, s_oe;
	logic [31:0] haddr, hwdata, hrdata, ch1_sample, ch2_sample;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int err_total = 0;
	int n_checks = 0;

	audio_port_tx_slot_mapper audio_port_tx_slot_mapper_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bclk(bclk), .fsync(fsync),
		.ch1_sample(ch1_sample), .ch2_sample(ch2_sample), .primary_data_out(p_d), .primary_data_oe(p_oe),
		.secondary_data_out(s_d), .secondary_data_oe(s_oe));
	audio_host_model audio_host_model_inst (.bclk(bclk), .fsync(fsync), .primary_data_out(p_d),
		.primary_data_oe(p_oe), .secondary_data_out(s_d), .secondary_data_oe(s_oe));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			if (n++ == 50) begin
				err_total++;
				close_out();
			end
			@(posedge hclk);
		end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, d, q);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, idx, 8'h00, q);
		check(nm, q, {24'h0, e});
	endtask

	task automatic fr(input int fmt, input int n, input int hl);
		@(posedge hclk);
		#3;
		audio_host_model_inst.run_frame(fmt, n, hl);
	endtask

	function automatic logic [15:0] g(input bit sec, input int s);
		for (int k = 0; k < 16; k++)
			g[15 - k] = sec ? audio_host_model_inst.sec_bits[s + k] : audio_host_model_inst.pri_bits[s + k];
	endfunction

	task automatic t_reset;
		rd_chk("pin sel", `IDX_PIN_SEL, 8'h00);
		rd_chk("ch1 cfg", `IDX_CH1_CFG, 8'h20);
		rd_chk("ch2 cfg", `IDX_CH2_CFG, 8'h21);
		rd_chk("unmapped", 8'h00, 8'h00);
		check("hresp", {31'h0, hresp}, 32'h0);
		$display("done reset values");
	endtask

	task automatic t_default;
		fr(0, 48, 0);
		check("slot0", g(0, 0), s1);
		check("slot1", g(0, 16), s2);
		check("unused", g(0, 32), 16'h0);
		check("second idle", g(1, 0), 16'h0);
		$display("done default frame");
	endtask

	task automatic t_pin_delay;
		logic [15:0] w;
		wr(`IDX_PIN_SEL, 8'h02);
		wr(`IDX_TX_OFFSET, 8'h03);
		rd_chk("pin sel back", `IDX_PIN_SEL, 8'h02);
		fr(0, 40, 0);
		w = g(0, 0);
		check("lead bits", {29'h0, w[15:13]}, 32'h0);
		check("delayed ch1", g(0, 3), s1);
		check("ch2 second", g(1, 19), s2);
		check("ch2 off first", g(0, 19), 16'h0);
		wr(`IDX_PIN_SEL, 8'h01);
		fr(0, 40, 0);
		check("ch1 second", g(1, 3), s1);
		check("ch2 first", g(0, 19), s2);
		wr(`IDX_PIN_SEL, 8'h00);
		wr(`IDX_TX_OFFSET, 8'h00);
		$display("done pin select and delay");
	endtask

	task automatic t_fill;
		wr(`IDX_CH1_CFG, 8'h00);
		fr(0, 40, 0);
		check("ch1 off", g(0, 0), 16'h0);
		wr(`IDX_TX_FILL, 8'h40);
		fr(0, 40, 0);
		check("ch1 off fill", g(0, 0), 16'hZZZZ);
		check("ch2 on", g(0, 16), s2);
		wr(`IDX_CH2_CFG, 8'h01);
		fr(0, 40, 0);
		check("ch2 off", g(0, 16), 16'hZZZZ);
		wr(`IDX_CH1_CFG, 8'h20);
		wr(`IDX_CH2_CFG, 8'h21);
		wr(`IDX_TX_FILL, 8'h00);
		$display("done enable and fill");
	endtask

	task automatic t_share;
		wr(`IDX_CH1_CFG, 8'h25);
		wr(`IDX_CH2_CFG, 8'h25);
		fr(0, 100, 0);
		check("shared slot", g(0, 80), s1);
		wr(`IDX_CH2_CFG, 8'h3F);
		rd_chk("ch2 back", `IDX_CH2_CFG, 8'h3F);
		fr(0, 512, 0);
		check("slot31", g(0, 496), s2);
		wr(`IDX_CH1_CFG, 8'h20);
		wr(`IDX_CH2_CFG, 8'h21);
		$display("done shared and last slot");
	endtask

	task automatic t_halves;
		wr(`IDX_FRAME_FMT, 8'h02);
		wr(`IDX_CH2_CFG, 8'h30);
		fr(int'(FMT_LJ), 64, 32);
		check("left slot0", g(0, 0), s1);
		check("left slot1", g(0, 16), 16'h0);
		check("right slot0", g(0, 32), s2);
		wr(`IDX_FRAME_FMT, 8'h01);
		fr(int'(FMT_I2S), 64, 32);
		check("i2s right slot0", g(0, 1), s2);
		check("i2s left slot0", g(0, 33), s1);
		wr(`IDX_FRAME_FMT, 8'h08);
		wr(`IDX_CH2_CFG, 8'h21);
		fr(0, 48, 0);
		check("wl24 slot0 head", g(0, 0), s1);
		check("wl24 slot0 tail", g(0, 8), {s1[7:0], 8'h12});
		check("wl24 slot1", g(0, 24), s2);
		$display("done half frames");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		ch1_sample = {s1, 16'h1234};
		ch2_sample = {s2, 16'h5678};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_default();
		t_pin_delay();
		t_fill();
		t_share();
		t_halves();
		close_out();
	end
endmodule // audio_port_tx_slot_mapper_tb
`default_nettype wire
